//--- rtl/pmbus_cmd_cfg.svh
/*
 * Command codes, fixed values and factory defaults of the PMBus command set.
 * Assumes nothing; included by the package and the design files.
 */
`ifndef PMBUS_CMD_CFG_SVH
`define PMBUS_CMD_CFG_SVH

// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define CMD_OPERATION 8'h01
`define CMD_ONOFF_CFG 8'h02
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_STORE_ALL 8'h11
`define CMD_RESTORE_ALL 8'h12
`define CMD_VOUT_FORMAT 8'h20
`define CMD_VOUT_SET 8'h21
`define CMD_FREQ_SET 8'h33
`define CMD_VIN_RISE 8'h35
`define CMD_VIN_FALL 8'h36
`define CMD_VOUT_OV_FAULT 8'h40
`define CMD_VOUT_OV_ACTION 8'h41
`define CMD_VOUT_OV_WARN 8'h42
`define CMD_IOUT_OC_FAULT 8'h46
`define CMD_IOUT_OC_ACTION 8'h47
`define CMD_IOUT_OC_WARN 8'h4A
`define CMD_OT_FAULT 8'h4F
`define CMD_OT_ACTION 8'h50
`define CMD_OT_WARN 8'h51
`define CMD_VIN_OV_FAULT 8'h55
`define CMD_PG_ASSERT 8'h5E
`define CMD_PG_NEGATE 8'h5F
`define CMD_TURN_ON_DELAY_TIME 8'h60

// ----------------------------------------------------------------
// Fixed values and factory defaults (linear encoded)
// ----------------------------------------------------------------
`define PAR_COUNT 19
`define VOUT_FORMAT_VAL 8'h14
`define DEF_OPERATION 16'h0080
`define DEF_ONOFF_NEG 16'h001D
`define DEF_ONOFF_POS 16'h001F
`define DEF_VOUT_SET 16'hBCCD
`define DEF_FREQ_SET 16'hF208
`define DEF_VIN_RISE 16'hE910
`define DEF_VIN_FALL 16'hE900
`define DEF_VOUT_OV_FAULT 16'hF000
`define DEF_VOUT_OV_ACTION 16'h00B8
`define DEF_VOUT_OV_WARN 16'hF000
`define DEF_IOUT_OC_FAULT 16'hE2B0
`define DEF_IOUT_OC_ACTION 16'h00F8
`define DEF_IOUT_OC_WARN 16'hE240
`define DEF_OT_FAULT 16'hF1F4
`define DEF_OT_ACTION 16'h00B8
`define DEF_OT_WARN 16'hF1CC
`define DEF_VIN_OV_FAULT 16'hEB70
`define DEF_PG_ASSERT 16'hB000
`define DEF_PG_NEGATE 16'h9000
`define DEF_TURN_ON_DELAY_TIME 16'hF80E

`endif

//--- rtl/pmbus_pkg.sv
/*
 * Shared types of the PMBus command block.
 * Assumes the configuration header is on the include path.
 */
`include "pmbus_cmd_cfg.svh"

package pmbus_pkg;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {L_IDLE, L_ADDR, L_CMD, L_WDATA, L_RDATA, L_IGNORE} link_state_e;

    typedef struct packed {
        logic scl;
        logic sda;
    } pins_s;

    typedef struct packed {
        logic known;
        logic isWord;
        logic writable;
        logic readable;
        logic [4:0] idx;
    } cmd_info_s;

    typedef logic [`PAR_COUNT-1:0][15:0] param_vec_t;

endpackage

//--- rtl/pin_sync.sv
/*
 * Two-flop synchroniser for bus pins.
 * Assumes inputs are asynchronous to mclk.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s st;

    if (WIDTH < 1) begin : g_check
        $error("WIDTH must be at least one");
    end

    // Idle bus level is high, so reset to ones
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '1;
        end else begin
            st <= '{first: din, second: st.first};
        end
    end

    assign dout = st.second;
endmodule

//--- rtl/param_flash.sv
/*
 * Nonvolatile parameter store, one word per parameter.
 * Assumes the array keeps its contents across resets; factory values are
 * present from power-up.
 */
`timescale 1ns/1ps
`include "pmbus_cmd_cfg.svh"

module param_flash import pmbus_pkg::*; #(
    parameter int NPAR = `PAR_COUNT,
    parameter bit POS_LOGIC = 1'b0
) (
    input wire logic mclk,
    input wire logic storeReq,
    input wire param_vec_t storeData,
    output param_vec_t rdData
);
    typedef logic [15:0] mem_t [NPAR];

    if (NPAR < 1 || NPAR > `PAR_COUNT) begin : g_check
        $error("NPAR must fit the parameter vector");
    end

    // ----------------------------------------------------------------
    // Factory contents, in parameter index order
    // ----------------------------------------------------------------
    function automatic logic [15:0] factory(input int i);
        logic [15:0] v;
        v = 16'h0000;
        case (i)
            0: v = `DEF_OPERATION;
            1: v = POS_LOGIC ? `DEF_ONOFF_POS : `DEF_ONOFF_NEG;
            2: v = `DEF_VOUT_SET;
            3: v = `DEF_FREQ_SET;
            4: v = `DEF_VIN_RISE;
            5: v = `DEF_VIN_FALL;
            6: v = `DEF_VOUT_OV_FAULT;
            7: v = `DEF_VOUT_OV_ACTION;
            8: v = `DEF_VOUT_OV_WARN;
            9: v = `DEF_IOUT_OC_FAULT;
            10: v = `DEF_IOUT_OC_ACTION;
            11: v = `DEF_IOUT_OC_WARN;
            12: v = `DEF_OT_FAULT;
            13: v = `DEF_OT_ACTION;
            14: v = `DEF_OT_WARN;
            15: v = `DEF_VIN_OV_FAULT;
            16: v = `DEF_PG_ASSERT;
            17: v = `DEF_PG_NEGATE;
            18: v = `DEF_TURN_ON_DELAY_TIME;
            default: v = 16'h0000;
        endcase
        return v;
    endfunction

    function automatic mem_t factoryAll();
        mem_t m;
        for (int i = 0; i < NPAR; i++) begin
            m[i] = factory(i);
        end
        return m;
    endfunction

    // No reset on purpose: contents must survive it
    mem_t mem = factoryAll();

    always_ff @(posedge mclk) begin
        if (storeReq) begin
            for (int i = 0; i < NPAR; i++) begin
                mem[i] <= storeData[i];
            end
        end
    end

    always_comb begin
        rdData = '0;
        for (int i = 0; i < NPAR; i++) begin
            rdData[i] = mem[i];
        end
    end
endmodule

//--- rtl/pmbus_command_parameter_set.sv
/*
 * PMBus command decoder and parameter store: serial slave, parameter RAM,
 * fault clear, store/restore to flash and power-good tracking.
 * Assumes SCL/SDA arrive asynchronously and resolve open-drain outside;
 * slaveAddr, converterRunning and voutMeas come from logic on mclk.
 */
`timescale 1ns/1ps
`include "pmbus_cmd_cfg.svh"


module pmbus_command_parameter_set import pmbus_pkg::*; #(
    parameter int NPAR = `PAR_COUNT,
    parameter bit POS_LOGIC = 1'b0
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [6:0] slaveAddr,
    input wire pins_s busPins,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic converterRunning,
    input wire logic [15:0] voutMeas,
    output param_vec_t paramWords,
    output logic powerGood,
    output logic faultClearPulse
);
    if (NPAR != `PAR_COUNT) begin : g_check
        $error("NPAR must match the fixed command table");
    end

    typedef struct packed {
        link_state_e ls;
        logic sclPrev;
        logic sdaPrev;
        logic [7:0] shift;
        logic [3:0] bitCnt;
        logic ackNext;
        logic inAck;
        logic rw;
        logic rdHigh;
        logic [7:0] cmd;
        logic cmdValid;
        logic [1:0] byteCnt;
        logic [15:0] data;
        logic sdaOe;
        logic sdaOut;
        param_vec_t par;
        logic booted;
        logic pg;
        logic faultClr;
        logic store;
    } state_s;

    state_s st;
    state_s nx;
    pins_s syncPins;
    param_vec_t flashRd;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;

    // ----------------------------------------------------------------
    // Pin synchroniser and flash
    // ----------------------------------------------------------------
    pin_sync #(.WIDTH($bits(pins_s))) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din(busPins),
        .dout(syncPins)
    );

    param_flash #(.NPAR(NPAR), .POS_LOGIC(POS_LOGIC)) u_flash (
        .mclk(mclk),
        .storeReq(st.store),
        .storeData(st.par),
        .rdData(flashRd)
    );

    // ----------------------------------------------------------------
    // Command table
    // ----------------------------------------------------------------
    function automatic cmd_info_s prm(input logic word, input logic [4:0] idx);
        return '{known: 1'b1, isWord: word, writable: 1'b1, readable: 1'b1, idx: idx};
    endfunction

    // Values are stored raw; encoding is the master's job
    function automatic cmd_info_s decode(input logic [7:0] c);
        cmd_info_s r;
        r = '0;
        case (c)
            `CMD_OPERATION: r = prm(1'b0, 5'd0);
            `CMD_ONOFF_CFG: r = prm(1'b0, 5'd1);
            `CMD_VOUT_SET: r = prm(1'b1, 5'd2);
            `CMD_FREQ_SET: r = prm(1'b1, 5'd3);
            `CMD_VIN_RISE: r = prm(1'b1, 5'd4);
            `CMD_VIN_FALL: r = prm(1'b1, 5'd5);
            `CMD_VOUT_OV_FAULT: r = prm(1'b1, 5'd6);
            `CMD_VOUT_OV_ACTION: r = prm(1'b0, 5'd7);
            `CMD_VOUT_OV_WARN: r = prm(1'b1, 5'd8);
            `CMD_IOUT_OC_FAULT: r = prm(1'b1, 5'd9);
            `CMD_IOUT_OC_ACTION: r = prm(1'b0, 5'd10);
            `CMD_IOUT_OC_WARN: r = prm(1'b1, 5'd11);
            `CMD_OT_FAULT: r = prm(1'b1, 5'd12);
            `CMD_OT_ACTION: r = prm(1'b0, 5'd13);
            `CMD_OT_WARN: r = prm(1'b1, 5'd14);
            `CMD_VIN_OV_FAULT: r = prm(1'b1, 5'd15);
            `CMD_PG_ASSERT: r = prm(1'b1, 5'd16);
            `CMD_PG_NEGATE: r = prm(1'b1, 5'd17);
            `CMD_TURN_ON_DELAY_TIME: r = prm(1'b1, 5'd18);
            `CMD_VOUT_FORMAT: r = '{known: 1'b1, isWord: 1'b0, writable: 1'b0, readable: 1'b1, idx: 5'd0};
            `CMD_CLEAR_FAULTS, `CMD_STORE_ALL, `CMD_RESTORE_ALL: r = '{known: 1'b1, default: '0};
            default: r = '0;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] readByte(input logic [7:0] c, input logic hi, input param_vec_t p);
        cmd_info_s i;
        logic [15:0] w;
        i = decode(c);
        w = p[i.idx];
        if (c == `CMD_VOUT_FORMAT) begin
            return hi ? 8'h00 : `VOUT_FORMAT_VAL;
        end
        if (!i.isWord && hi) begin
            return 8'h00;
        end
        return hi ? w[15:8] : w[7:0];
    endfunction

    // ----------------------------------------------------------------
    // Bus events
    // ----------------------------------------------------------------
    // Own SDA changes only while SCL is low, so they never fake a start or stop
    assign sclRise = syncPins.scl & ~st.sclPrev;
    assign sclFall = ~syncPins.scl & st.sclPrev;
    assign startEv = syncPins.scl & st.sclPrev & st.sdaPrev & ~syncPins.sda;
    assign stopEv = syncPins.scl & st.sclPrev & ~st.sdaPrev & syncPins.sda;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        cmd_info_s info;
        cmd_info_s inInfo;
        logic [7:0] inByte;
        info = decode(st.cmd);
        inByte = {st.shift[6:0], syncPins.sda};
        inInfo = decode(inByte);
        nx = st;
        nx.faultClr = 1'b0;
        nx.store = 1'b0;
        nx.sclPrev = syncPins.scl;
        nx.sdaPrev = syncPins.sda;
        if (!st.booted) begin
            nx.booted = 1'b1;
            nx.par = flashRd;
        end
        // Levels read zero before the boot load, so power good waits for it
        if (st.booted && voutMeas >= st.par[16]) begin
            nx.pg = 1'b1;
        end else if (st.booted && voutMeas <= st.par[17]) begin
            nx.pg = 1'b0;
        end
        if (startEv) begin
            nx.ls = L_ADDR;
            nx.bitCnt = 4'h0;
            nx.ackNext = 1'b0;
            nx.inAck = 1'b0;
            nx.sdaOe = 1'b0;
        end else if (stopEv) begin
            if (st.ls == L_WDATA && st.byteCnt == 2'h0) begin
                case (st.cmd)
                    `CMD_CLEAR_FAULTS: nx.faultClr = 1'b1;
                    `CMD_STORE_ALL: nx.store = 1'b1;
                    `CMD_RESTORE_ALL: begin
                        // Ignored while running rather than upsetting the output
                        if (!converterRunning) begin
                            nx.par = flashRd;
                        end
                    end
                    default: ;
                endcase
            end else if (st.ls == L_WDATA && info.writable && st.byteCnt == (info.isWord ? 2'h2 : 2'h1)) begin
                nx.par[info.idx] = info.isWord ? st.data : {8'h00, st.data[7:0]};
            end
            nx.ls = L_IDLE;
            nx.sdaOe = 1'b0;
            nx.ackNext = 1'b0;
            nx.inAck = 1'b0;
            nx.cmdValid = 1'b0;
        end else if (sclRise) begin
            unique case (st.ls)
                L_IDLE, L_IGNORE: ;
                L_ADDR, L_CMD, L_WDATA: begin
                    if (!st.inAck) begin
                        nx.shift = inByte;
                        nx.bitCnt = st.bitCnt + 4'h1;
                        if (st.bitCnt == 4'h7) begin
                            nx.ls = L_IGNORE;
                            if (st.ls == L_ADDR) begin
                                // Read needs a command set earlier in the same transfer
                                if (inByte[7:1] == slaveAddr && (!inByte[0] || st.cmdValid)) begin
                                    nx.ls = L_ADDR;
                                    nx.ackNext = 1'b1;
                                    nx.rw = inByte[0];
                                end
                            end else if (st.ls == L_CMD) begin
                                nx.cmd = inByte;
                                if (inInfo.known) begin
                                    nx.ls = L_CMD;
                                    nx.ackNext = 1'b1;
                                end
                            end else if (info.writable && st.byteCnt < (info.isWord ? 2'h2 : 2'h1)) begin
                                nx.ls = L_WDATA;
                                nx.ackNext = 1'b1;
                                nx.byteCnt = st.byteCnt + 2'h1;
                                nx.data = (st.byteCnt == 2'h0) ? {8'h00, inByte} : {inByte, st.data[7:0]};
                            end
                        end
                    end
                end
                L_RDATA: begin
                    if (st.bitCnt == 4'h8) begin
                        if (!syncPins.sda && !st.rdHigh) begin
                            nx.shift = readByte(st.cmd, 1'b1, st.par);
                            nx.rdHigh = 1'b1;
                            nx.bitCnt = 4'h0;
                        end else begin
                            nx.ls = L_IGNORE;
                        end
                    end else begin
                        nx.shift = {st.shift[6:0], 1'b0};
                        nx.bitCnt = st.bitCnt + 4'h1;
                    end
                end
            endcase
        end else if (sclFall) begin
            if (st.ackNext) begin
                nx.sdaOe = 1'b1;
                nx.ackNext = 1'b0;
                nx.inAck = 1'b1;
            end else if (st.inAck) begin
                nx.inAck = 1'b0;
                nx.sdaOe = 1'b0;
                nx.bitCnt = 4'h0;
                if (st.ls == L_ADDR && st.rw) begin
                    nx.ls = L_RDATA;
                    nx.rdHigh = 1'b0;
                    nx.shift = readByte(st.cmd, 1'b0, st.par);
                    nx.sdaOe = ~nx.shift[7];
                end else if (st.ls == L_ADDR) begin
                    nx.ls = L_CMD;
                end else if (st.ls == L_CMD) begin
                    nx.ls = L_WDATA;
                    nx.cmdValid = 1'b1;
                    nx.byteCnt = 2'h0;
                end
            end else if (st.ls == L_RDATA) begin
                nx.sdaOe = (st.bitCnt == 4'h8) ? 1'b0 : ~st.shift[7];
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{ls: L_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};
        end else begin
            st <= nx;
        end
    end

    assign sdaOut = st.sdaOut;
    assign sdaOe = st.sdaOe;
    assign paramWords = st.par;
    assign powerGood = st.pg;
    assign faultClearPulse = st.faultClr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_send_done;
        stopEv && st.ls == L_WDATA && st.byteCnt == 2'h0;
    endsequence

    sequence s_write_done(int n);
        stopEv && st.ls == L_WDATA && st.byteCnt == n;
    endsequence

    a_fault_clear: assert property (s_send_done ##0 (st.cmd == `CMD_CLEAR_FAULTS) |=> faultClearPulse ##1 !faultClearPulse)
        else $error("fault clear pulse missing");
    a_flash_store: assert property (s_send_done ##0 (st.cmd == `CMD_STORE_ALL) |=> st.store ##1 paramWords == flashRd)
        else $error("store to flash missing");
    a_flash_restore: assert property (s_send_done ##0 (st.cmd == `CMD_RESTORE_ALL && !converterRunning) |=> paramWords == $past(flashRd))
        else $error("restore from flash missing");
    a_restore_blocked: assert property (s_send_done ##0 (st.cmd == `CMD_RESTORE_ALL && converterRunning) |=> $stable(paramWords))
        else $error("restore acted while running");
    a_boot_load: assert property (!st.booted |=> st.booted && paramWords == $past(flashRd))
        else $error("power-up load missing");
    a_format_read: assert property (sclFall && st.inAck && st.ls == L_ADDR && st.rw && st.cmd == `CMD_VOUT_FORMAT |=> st.shift == `VOUT_FORMAT_VAL && st.ls == L_RDATA)
        else $error("format byte wrong");
    a_vout_write: assert property (s_write_done(2) ##0 (st.cmd == `CMD_VOUT_SET) |=> paramWords[2] == $past(st.data))
        else $error("setpoint word not written");
    a_operation_write: assert property (s_write_done(1) ##0 (st.cmd == `CMD_OPERATION) |=> paramWords[0] == {8'h00, $past(st.data[7:0])})
        else $error("on/off byte not written");
    a_pg_assert: assert property (voutMeas >= paramWords[16] ##1 voutMeas >= paramWords[16] |-> powerGood)
        else $error("power good not asserted");
    a_pg_negate: assert property (voutMeas <= paramWords[17] && voutMeas < paramWords[16] |=> !powerGood)
        else $error("power good not negated");
endmodule

//--- verification/pmbus_master_model.sv
/*
 * Bus master model: start, stop, byte and whole transfers on SCL/SDA.
 * Assumes SDA is pulled up outside; sdaDrv high pulls it low.
 */
`timescale 1ns/1ps

module pmbus_master_model (
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaWire
);
    // ----------------------------------------------------------------
    // Bit level, 200 ns a bit, SDA moved mid-low, SCL idle high
    // ----------------------------------------------------------------
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b0;
    end
    task automatic bitOut(input logic b);
        #50 sdaDrv = ~b;
        #50 scl = 1'b1;
        #100 scl = 1'b0;
    endtask
    task automatic bitIn(output logic b);
        #50 sdaDrv = 1'b0;
        #50 scl = 1'b1;
        b = sdaWire;
        #100 scl = 1'b0;
    endtask
    task automatic startC();
        #50 sdaDrv = 1'b0;
        #50 scl = 1'b1;
        #100 sdaDrv = 1'b1;
        #100 scl = 1'b0;
    endtask
    // Long tail so actions taken at stop have landed
    task automatic stopC();
        #50 sdaDrv = 1'b1;
        #50 scl = 1'b1;
        #100 sdaDrv = 1'b0;
        #200;
    endtask
    // ----------------------------------------------------------------
    // Bytes and transfers, words low byte first
    // ----------------------------------------------------------------
    task automatic byteOut(input logic [7:0] v, inout logic ok);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bitOut(v[i]);
        end
        bitIn(a);
        ok = ok & ~a;
    endtask
    task automatic byteIn(input logic last, output logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            bitIn(v[i]);
        end
        bitOut(last);
    endtask
    task automatic writeCmd(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input int n,
                            output logic ok);
        ok = 1'b1;
        startC();
        byteOut({a, 1'b0}, ok);
        byteOut(c, ok);
        for (int i = 0; i < n; i++) begin
            byteOut(d[8*i +: 8], ok);
        end
        stopC();
    endtask
    task automatic readCmd(input logic [6:0] a, input logic [7:0] c, input int n, output logic [15:0] d,
                           output logic ok);
        ok = 1'b1;
        d = 16'h0000;
        startC();
        byteOut({a, 1'b0}, ok);
        byteOut(c, ok);
        startC();
        byteOut({a, 1'b1}, ok);
        for (int i = 0; i < n; i++) begin
            byteIn(i == n - 1, d[8*i +: 8]);
        end
        stopC();
    endtask
endmodule

//--- verification/testbench.sv
/*
 * Self-checking bench: bus reads and writes, store/restore, power good.
 * Assumes the command header and package are compiled first.
 */
`timescale 1ns/1ps
`include "pmbus_cmd_cfg.svh"
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench import pmbus_pkg::*;;
    localparam logic [6:0] ADDR = 7'h2A;
    localparam logic [15:0] DEFS [19] = '{`DEF_OPERATION, `DEF_ONOFF_NEG, `DEF_VOUT_SET, `DEF_FREQ_SET,
        `DEF_VIN_RISE, `DEF_VIN_FALL, `DEF_VOUT_OV_FAULT, `DEF_VOUT_OV_ACTION, `DEF_VOUT_OV_WARN,
        `DEF_IOUT_OC_FAULT, `DEF_IOUT_OC_ACTION, `DEF_IOUT_OC_WARN, `DEF_OT_FAULT, `DEF_OT_ACTION,
        `DEF_OT_WARN, `DEF_VIN_OV_FAULT, `DEF_PG_ASSERT, `DEF_PG_NEGATE, `DEF_TURN_ON_DELAY_TIME};
    localparam logic [7:0] WC [15] = '{8'h02, 8'h33, 8'h35, 8'h36, 8'h40, 8'h41, 8'h42, 8'h46, 8'h47,
        8'h4A, 8'h4F, 8'h50, 8'h51, 8'h55, 8'h60};
    localparam int WI [15] = '{1, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 18};
    localparam logic [15:0] WV [15] = '{16'h000D, 16'hF1F8, 16'hE920, 16'hE910, 16'hE000, 16'h00A8,
        16'hD800, 16'hE2A0, 16'h00E8, 16'hE230, 16'hF1E0, 16'h0098, 16'hF1B8, 16'hEB60, 16'hF810};
    localparam logic [15:0] PV [4] = '{16'hC000, 16'hA700, 16'hA667, 16'hB000};
    logic mclk, rst_n, sdaOut, sdaOe, converterRunning, powerGood, faultClearPulse, sclM, sdaDrv, sdaWire;
    logic [15:0] voutMeas;
    pins_s busPins;
    param_vec_t paramWords;
    int mismatches, checksDone, clearCount;

    assign sdaWire = ~(sdaOe | sdaDrv);
    assign busPins = {sclM, sdaWire};

    pmbus_command_parameter_set #(.NPAR(`PAR_COUNT), .POS_LOGIC(1'b0)) i_dut (.mclk(mclk), .rst_n(rst_n),
        .slaveAddr(ADDR), .busPins(busPins), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .converterRunning(converterRunning), .voutMeas(voutMeas), .paramWords(paramWords),
        .powerGood(powerGood), .faultClearPulse(faultClearPulse));
    pmbus_master_model i_master (.scl(sclM), .sdaDrv(sdaDrv), .sdaWire(sdaWire));

    // ----------------------------------------------------------------
    // Clock, pulse counter, watchdog and shared tasks
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (faultClearPulse === 1'b1) begin
            clearCount++;
        end
    end
    // Whole run is about 0.36 ms of bus traffic
    initial begin
        #2000000;
        mismatches++;
        complete_run();
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic doReset();
        rst_n = 1'b0;
        repeat (20) @(posedge mclk);
        #2 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
        #2;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, input logic expOk);
        logic ok;
        i_master.writeCmd(ADDR, c, d, n, ok);
        `CHECK(ok, expOk)
    endtask
    task automatic rdChk(input logic [7:0] c, input int n, input logic [15:0] exp);
        logic ok;
        logic [15:0] d;
        i_master.readCmd(ADDR, c, n, d, ok);
        `CHECK({ok, d}, {1'b1, exp})
    endtask
    task automatic setRun(input logic v);
        @(posedge mclk);
        #2 converterRunning = v;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        int nb;
        logic okOther;
        mismatches = 0;
        checksDone = 0;
        clearCount = 0;
        converterRunning = 1'b0;
        voutMeas = 16'h0000;
        doReset();
        for (int i = 0; i < 19; i++) begin
            `CHECK(paramWords[i], DEFS[i])
        end
        `CHECK(paramWords[18:12], {DEFS[18], DEFS[17], DEFS[16], DEFS[15], DEFS[14], DEFS[13], DEFS[12]})
        rdChk(8'h01, 1, 16'h0080);
        `CHECK(sdaOut, 1'b0)
        rdChk(8'h20, 1, 16'h0014);
        wr(8'h20, 16'h0055, 1, 1'b0);
        rdChk(8'h20, 1, 16'h0014);
        rdChk(8'h21, 2, 16'hBCCD);
        for (int i = 0; i < 15; i++) begin
            nb = (DEFS[WI[i]][15:8] == 8'h00) ? 1 : 2;
            wr(WC[i], WV[i], nb, 1'b1);
            `CHECK(paramWords[WI[i]], WV[i])
            rdChk(WC[i], nb, WV[i]);
        end
        wr(8'h21, 16'hC000, 2, 1'b1);
        wr(8'h01, 16'h0000, 1, 1'b1);
        `CHECK(paramWords[0], 16'h0000)
        i_master.writeCmd(ADDR ^ 7'h01, 8'h01, 16'h0080, 1, okOther);
        `CHECK({okOther, paramWords[0]}, {1'b0, 16'h0000})
        wr(8'h11, 16'h0000, 0, 1'b1);
        wr(8'h21, 16'hB000, 2, 1'b1);
        wr(8'h01, 16'h0080, 1, 1'b1);
        setRun(1'b1);
        wr(8'h12, 16'h0000, 0, 1'b1);
        `CHECK({paramWords[2], paramWords[0]}, 32'hB000_0080)
        setRun(1'b0);
        wr(8'h12, 16'h0000, 0, 1'b1);
        `CHECK({paramWords[2], paramWords[0]}, 32'hC000_0000)
        @(posedge mclk);
        #2 doReset();
        `CHECK(paramWords[2], 16'hC000)
        `CHECK(clearCount, 0)
        wr(8'h03, 16'h0000, 0, 1'b1);
        `CHECK(clearCount, 1)
        wr(8'h5E, 16'hC000, 2, 1'b1);
        wr(8'h5F, 16'hA667, 2, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #2 voutMeas = PV[i];
            repeat (4) @(posedge mclk);
            #1 `CHECK(powerGood, (i < 2))
        end
        complete_run();
    end
endmodule
